/* File: dpr_map.svh */
// constants for the d-phy re-timer mode control
//
// Behaviour
// - forward one to four data lanes plus clock
// - eq strap latched at reset release
// - equalizer override replaces strapped value
// - edge-rate strap latched at reset release
// - hs edge-rate override replaces strapped value
// - lp edge time from swing/preemph straps, overridable
// - two pre-emphasis levels, strapped, overridable
// - swing and emphasis from nine strap combinations
// - continuous de-skew, retimed data centred in clock
// - de-skew only in hs, four ui latency
// - reset low drives all outputs to lp00
// - lane inputs ignored while in shutdown
// - reset release enters lp pass-through
// - lp mode passes lp, terminations off
// - reverse lp traffic only on lane zero
// - watch for ulps; ulps stops hs logic
// - ulps entered only from lp mode
// - hs request enters hs, terminations, de-skew
// - hs exit returns to lp at once
// - overrides accepted only out of reset
// - eq and edge straps become serial pins
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH

// three-level strap codes
`define DPR_LVL_LOW 2'h0
`define DPR_LVL_MID 2'h1
`define DPR_LVL_HIGH 2'h2

// lp line states {p,n}
`define DPR_LP00 2'h0
`define DPR_LP01 2'h1
`define DPR_LP10 2'h2
`define DPR_LP11 2'h3

// lp edge time codes: 18, 21, 27 ns
`define DPR_LPE_18NS 2'h0
`define DPR_LPE_21NS 2'h1
`define DPR_LPE_27NS 2'h2

// lp sequences, oldest state in the top bits
`define DPR_SEQ_HS_REQ 6'h34
`define DPR_SEQ_ESCAPE 10'h384
`define DPR_SEQ_TURN 10'h388

// de-skew latency in unit intervals (two link clock periods)
`define DPR_DESKEW_UI 4
`define DPR_CTR_DLY 2

`endif

/* File: dpr_pkg.sv */
// types of the d-phy re-timer mode control
package dpr_pkg;

	typedef enum logic [1:0] {
		DPR_SHUT = 2'b00,
		DPR_LP = 2'b01,
		DPR_ULPS = 2'b10,
		DPR_HS = 2'b11
	} dpr_mode_t;

	typedef struct packed {
		logic rx_equalizer_setting_we;
		logic [1:0] rx_equalizer_setting;
		logic hs_edge_rate_setting_we;
		logic [1:0] hs_edge_rate_setting;
		logic lp_edge_rate_setting_we;
		logic [1:0] lp_edge_rate_setting;
		logic pre_we;
		logic pre;
	} dpr_ovr_t;

	typedef struct packed {
		logic [1:0] rx_eq;
		logic [1:0] hs_edge;
		logic [1:0] lp_edge;
		logic swing_220;
		logic preemph;
	} dpr_cfg_t;

endpackage : dpr_pkg

/* File: dpr_sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dpr_sync2 #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// no reset: the straps must track the pins while reset is held
	always_ff @(posedge core_clk) begin
		meta_r <= d;
		q <= meta_r;
	end
endmodule : dpr_sync2

/* File: dpr_buf2.sv */
// small flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module dpr_buf2 #(
	parameter int W = 4,
	parameter int DEPTH = 2
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// pointers wrap by overflow, so only powers of two are served
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("dpr_buf2: DEPTH must be a power of two, at least 2");
	end

	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (cnt_r != (AW+1)'(DEPTH)) || pop;
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn || flush) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_r + AW'(push);
			rp_r <= rp_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : dpr_buf2

/* File: dpr_mode_ctrl.sv */
// mode control, strap handling and hs retiming of the re-timer
`timescale 1ns/1ns
`include "dpr_map.svh"
module dpr_mode_ctrl #(
	parameter int NLANES = 4,
	parameter int CTR_DLY = `DPR_CTR_DLY
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [NLANES-1:0][1:0] input_data_lanes_lp,
	input wire logic [NLANES-1:0] input_data_lanes_hs,
	input wire logic [1:0] input_clock_lane_lp,
	input wire logic input_clock_lane_hs,
	output logic [NLANES-1:0][1:0] output_data_lanes_lp,
	output logic [NLANES-1:0] output_data_lanes_hs,
	output logic output_data_lanes_hs_valid,
	output logic [1:0] output_clock_lane_lp,
	output logic output_clock_lane_hs,
	input wire logic hs_sink_ready,
	output logic hs_overrun,
	output logic [1:0] input_lane_zero_drv,
	output logic input_lane_zero_oe_n,
	input wire logic [1:0] output_lane_zero_rx,
	output logic output_lane_zero_oe_n,
	input wire logic [1:0] eq_strap_serial_clock,
	input wire logic [1:0] edge_rate_strap_serial_data,
	input wire logic [1:0] swing_strap,
	input wire logic [1:0] preemph_strap,
	input wire dpr_pkg::dpr_ovr_t ovr,
	output dpr_pkg::dpr_cfg_t cfg,
	output dpr_pkg::dpr_mode_t mode,
	output logic reverse_active,
	output logic hs_rx_term_en,
	output logic hs_tx_term_en,
	output logic deskew_en,
	output logic hs_logic_en
);
	import dpr_pkg::*;

	localparam int PD = `DPR_DESKEW_UI - 1;
	localparam int SW = 3 * NLANES + 13;

	// refuse sizes that the lane packing and clock delay cannot serve
	if (NLANES < 1 || NLANES > 4) begin : g_bad_lanes
		$error("dpr_mode_ctrl: NLANES must be 1 to 4");
	end
	if (CTR_DLY < 1) begin : g_bad_dly
		$error("dpr_mode_ctrl: CTR_DLY must be at least 1");
	end

	// every pin input crosses two flops before use
	logic [SW-1:0] sync_q;
	dpr_sync2 #(.W(SW)) u_sync (
		.core_clk(core_clk),
		.d({input_data_lanes_lp, input_data_lanes_hs, input_clock_lane_lp,
			input_clock_lane_hs, output_lane_zero_rx, eq_strap_serial_clock,
			edge_rate_strap_serial_data, swing_strap, preemph_strap}),
		.q(sync_q)
	);

	wire [NLANES-1:0][1:0] in_lp_s = sync_q[SW-1 -: 2*NLANES];
	wire [NLANES-1:0] in_hs_s = sync_q[NLANES+12 -: NLANES];
	wire [1:0] clk_lp_s = sync_q[12:11];
	wire clk_hs_s = sync_q[10];
	wire [1:0] rev_lp_s = sync_q[9:8];
	wire [1:0] eq_s = sync_q[7:6];
	wire [1:0] erc_s = sync_q[5:4];
	wire [1:0] swing_s = sync_q[3:2];
	wire [1:0] pre_s = sync_q[1:0];
	wire [1:0] lane0_s = in_lp_s[0];

	// straps and overrides
	logic [1:0] eq_strap_r, erc_strap_r, swing_strap_r, pre_strap_r;
	logic rx_equalizer_setting_ov_r, erc_ov_r, lpe_ov_r, pre_ov_r;
	logic [1:0] rx_equalizer_setting_val_r, erc_val_r, lpe_val_r;
	logic pre_val_r;
	dpr_cfg_t cfg_r;

	// straps track the pins during reset and freeze at the release;
	// afterwards eq/edge pins serve the serial interface and are ignored here
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			eq_strap_r <= eq_s;
			erc_strap_r <= erc_s;
			swing_strap_r <= swing_s;
			pre_strap_r <= pre_s;
		end
	end

	// overrides only land out of reset and stay until the next reset
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rx_equalizer_setting_ov_r <= 1'b0;
			erc_ov_r <= 1'b0;
			lpe_ov_r <= 1'b0;
			pre_ov_r <= 1'b0;
			rx_equalizer_setting_val_r <= `DPR_LVL_LOW;
			erc_val_r <= `DPR_LVL_LOW;
			lpe_val_r <= `DPR_LPE_18NS;
			pre_val_r <= 1'b0;
		end else begin
			if (ovr.rx_equalizer_setting_we) begin
				rx_equalizer_setting_ov_r <= 1'b1;
				rx_equalizer_setting_val_r <= ovr.rx_equalizer_setting;
			end
			if (ovr.hs_edge_rate_setting_we) begin
				erc_ov_r <= 1'b1;
				erc_val_r <= ovr.hs_edge_rate_setting;
			end
			if (ovr.lp_edge_rate_setting_we) begin
				lpe_ov_r <= 1'b1;
				lpe_val_r <= ovr.lp_edge_rate_setting;
			end
			if (ovr.pre_we) begin
				pre_ov_r <= 1'b1;
				pre_val_r <= ovr.pre;
			end
		end
	end

	wire sw_low = (swing_strap_r == `DPR_LVL_LOW);
	wire sw_mid = (swing_strap_r == `DPR_LVL_MID);
	// unused pad code 3 counts as high
	wire sw_high = swing_strap_r[1];
	wire pe_low = (pre_strap_r == `DPR_LVL_LOW);
	wire pe_high = (pre_strap_r == `DPR_LVL_HIGH);
	// nine-combination table folded into terms
	wire strap_220 = sw_high || (sw_low && pe_high);
	wire strap_pre = pe_high;
	wire [1:0] strap_lpe = (pe_low && !sw_mid) ? `DPR_LPE_18NS :
		((pe_low && sw_mid) || (!pe_low && sw_low)) ? `DPR_LPE_27NS : `DPR_LPE_21NS;
	dpr_cfg_t cfg_nxt;
	assign cfg_nxt = '{
		rx_eq: rx_equalizer_setting_ov_r ? rx_equalizer_setting_val_r : eq_strap_r,
		hs_edge: erc_ov_r ? erc_val_r : erc_strap_r,
		lp_edge: lpe_ov_r ? lpe_val_r : strap_lpe,
		swing_220: strap_220,
		preemph: pre_ov_r ? pre_val_r : strap_pre
	};

	always_ff @(posedge core_clk) begin
		cfg_r <= cfg_nxt;
	end

	// lp sequence watchers on lane 0, forward and reverse
	logic [9:0] fwd_hist_r, rev_hist_r;
	wire fwd_chg = (lane0_s != fwd_hist_r[1:0]);
	wire rev_chg = (rev_lp_s != rev_hist_r[1:0]);
	wire [9:0] fwd_hist_nxt = {fwd_hist_r[7:0], lane0_s};
	wire [9:0] rev_hist_nxt = {rev_hist_r[7:0], rev_lp_s};
	wire hs_req_hit = fwd_chg && (fwd_hist_nxt[5:0] == `DPR_SEQ_HS_REQ);
	wire esc_hit = fwd_chg && (fwd_hist_nxt == `DPR_SEQ_ESCAPE);
	wire turn_hit = fwd_chg && (fwd_hist_nxt == `DPR_SEQ_TURN);
	wire turn_back = rev_chg && (rev_hist_nxt == `DPR_SEQ_TURN);

	dpr_mode_t mode_r, mode_nxt;
	logic rev_r;

	// lp watching is halted in shutdown, so input activity is lost
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fwd_hist_r <= {5{`DPR_LP11}};
			rev_hist_r <= {5{`DPR_LP11}};
		end else begin
			if (fwd_chg) begin
				fwd_hist_r <= fwd_hist_nxt;
			end
			if (rev_chg) begin
				rev_hist_r <= rev_hist_nxt;
			end
		end
	end

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			DPR_SHUT: mode_nxt = DPR_LP;
			DPR_LP: begin
				if (rev_r) begin
					mode_nxt = DPR_LP;
				end else if (hs_req_hit) begin
					mode_nxt = DPR_HS;
				end else if (esc_hit) begin
					mode_nxt = DPR_ULPS;
				end
			end
			DPR_HS: begin
				if (lane0_s == `DPR_LP11) begin
					mode_nxt = DPR_LP;
				end
			end
			DPR_ULPS: begin
				if (lane0_s == `DPR_LP11) begin
					mode_nxt = DPR_LP;
				end
			end
			default: mode_nxt = DPR_SHUT;
		endcase
	end

	// turnaround only from lp; lane 0 is the only reverse lane
	wire rev_nxt = (mode_r == DPR_LP) && (rev_r ? !turn_back : turn_hit);
	wire hs_nxt = (mode_nxt == DPR_HS);
	wire leave_hs = (mode_r == DPR_HS) && !hs_nxt;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mode_r <= DPR_SHUT;
			rev_r <= 1'b0;
			hs_rx_term_en <= 1'b0;
			hs_tx_term_en <= 1'b0;
			deskew_en <= 1'b0;
			hs_logic_en <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			rev_r <= rev_nxt;
			hs_rx_term_en <= hs_nxt;
			hs_tx_term_en <= hs_nxt;
			deskew_en <= hs_nxt;
			hs_logic_en <= (mode_nxt != DPR_ULPS);
		end
	end

	// lp pass-through; hs and shutdown show lp00 on the lp drivers
	wire lp_pass = (mode_nxt == DPR_LP) || (mode_nxt == DPR_ULPS);
	logic [NLANES-1:0][1:0] out_lp_r;
	logic [1:0] clk_lp_r;
	logic [1:0] in0_drv_r;
	logic in0_oe_n_r, out0_oe_n_r;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			out_lp_r <= '0;
			clk_lp_r <= `DPR_LP00;
			in0_drv_r <= `DPR_LP00;
			in0_oe_n_r <= 1'b1;
			out0_oe_n_r <= 1'b0;
		end else begin
			out_lp_r <= lp_pass ? in_lp_s : '0;
			clk_lp_r <= lp_pass ? clk_lp_s : `DPR_LP00;
			in0_drv_r <= rev_lp_s;
			in0_oe_n_r <= !rev_nxt;
			out0_oe_n_r <= rev_nxt;
		end
	end

	// hs retiming: each edge of the sampled link clock carries one ui
	logic clk_d_r;
	logic [CTR_DLY-1:0] cdl_r;
	logic clk_out_r;
	wire link_edge = (clk_hs_s != clk_d_r);
	wire hs_on = (mode_r == DPR_HS) && hs_nxt;

	logic [PD-1:0][NLANES-1:0] pipe_r;
	logic [PD-1:0] pv_r;
	wire buf_in_ready;
	wire buf_out_valid;
	wire [NLANES-1:0] buf_out_data;
	wire shift = link_edge && hs_on && buf_in_ready;
	wire push = shift && pv_r[PD-1];
	wire pop = link_edge && hs_on && hs_sink_ready && buf_out_valid;

	// a full buffer freezes the pipe; the source cannot be held off,
	// so a word arriving then is dropped and flagged
	dpr_buf2 #(.W(NLANES), .DEPTH(2)) u_buf (
		.core_clk(core_clk),
		.resetn(resetn),
		.flush(leave_hs),
		.in_valid(push),
		.in_ready(buf_in_ready),
		.in_data(pipe_r[PD-1]),
		.out_valid(buf_out_valid),
		.out_ready(pop),
		.out_data(buf_out_data)
	);

	logic [NLANES-1:0] out_hs_r;
	logic out_hs_v_r;
	logic overrun_r;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			clk_d_r <= 1'b0;
			cdl_r <= '0;
			clk_out_r <= 1'b0;
		end else begin
			clk_d_r <= clk_hs_s;
			cdl_r <= CTR_DLY'({cdl_r, hs_on ? clk_hs_s : 1'b0});
			clk_out_r <= cdl_r[CTR_DLY-1];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn || leave_hs) begin
			pv_r <= '0;
			pipe_r <= '0;
			out_hs_r <= '0;
			out_hs_v_r <= 1'b0;
		end else begin
			if (shift) begin
				pipe_r <= (PD*NLANES)'({pipe_r, in_hs_s});
				pv_r <= PD'({pv_r, 1'b1});
			end
			if (pop) begin
				out_hs_r <= buf_out_data;
			end
			out_hs_v_r <= pop;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn || (mode_r != DPR_HS && hs_nxt)) begin
			overrun_r <= 1'b0;
		end else if (link_edge && hs_on && !buf_in_ready) begin
			overrun_r <= 1'b1;
		end
	end

	assign output_data_lanes_lp = out_lp_r;
	assign output_data_lanes_hs = out_hs_r;
	assign output_data_lanes_hs_valid = out_hs_v_r;
	assign output_clock_lane_lp = clk_lp_r;
	assign output_clock_lane_hs = clk_out_r;
	assign hs_overrun = overrun_r;
	assign input_lane_zero_drv = in0_drv_r;
	assign input_lane_zero_oe_n = in0_oe_n_r;
	assign output_lane_zero_oe_n = out0_oe_n_r;
	assign cfg = cfg_r;
	assign mode = mode_r;
	assign reverse_active = rev_r;

	default clocking dpr_cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	property p_shut_lp00;
		!$past(resetn) |-> (out_lp_r == '0 && clk_lp_r == `DPR_LP00 && mode_r == DPR_SHUT);
	endproperty
	a_shut_lp00: assert property (p_shut_lp00) else $error("outputs not lp00 after shutdown");

	property p_wake_lp;
		(!$past(resetn) && resetn) |=> mode_r == DPR_LP;
	endproperty
	a_wake_lp: assert property (p_wake_lp) else $error("no lp mode after reset release");

	property p_lp_no_term;
		mode_r != DPR_HS |-> !hs_rx_term_en && !hs_tx_term_en && !deskew_en;
	endproperty
	a_lp_no_term: assert property (p_lp_no_term) else $error("terminations on outside hs");

	property p_ulps_from_lp;
		(mode_r == DPR_ULPS && $past(mode_r) != DPR_ULPS) |-> $past(mode_r) == DPR_LP;
	endproperty
	a_ulps_from_lp: assert property (p_ulps_from_lp) else $error("ulps entered from wrong mode");

	property p_ulps_hs_off;
		mode_r == DPR_ULPS |-> !hs_logic_en && out_hs_v_r == 1'b0;
	endproperty
	a_ulps_hs_off: assert property (p_ulps_hs_off) else $error("hs logic active in ulps");

	property p_hs_enter;
		(mode_r == DPR_LP && !rev_r && hs_req_hit) |=> mode_r == DPR_HS && hs_rx_term_en && deskew_en;
	endproperty
	a_hs_enter: assert property (p_hs_enter) else $error("hs request not honoured");

	property p_hs_exit;
		(mode_r == DPR_HS && lane0_s == `DPR_LP11) |=> mode_r == DPR_LP ##1 out_lp_r[0] == $past(lane0_s);
	endproperty
	a_hs_exit: assert property (p_hs_exit) else $error("hs exit not taken at once");

	property p_flush;
		($past(mode_r) == DPR_HS && mode_r != DPR_HS) |-> pv_r == '0 && out_hs_r == '0 && !out_hs_v_r;
	endproperty
	a_flush: assert property (p_flush) else $error("de-skew pipe not flushed");

	property p_reverse_lane0;
		rev_r |-> !input_lane_zero_oe_n && output_lane_zero_oe_n;
	endproperty
	a_reverse_lane0: assert property (p_reverse_lane0) else $error("lane 0 direction wrong");

	property p_override;
		ovr.rx_equalizer_setting_we |=> ##1 cfg_r.rx_eq == $past(ovr.rx_equalizer_setting, 2);
	endproperty
	a_override: assert property (p_override) else $error("equalizer override lost");

	c_hs: cover property (mode_r == DPR_LP ##1 mode_r == DPR_HS);
	c_ulps: cover property (mode_r == DPR_ULPS);
	c_reverse: cover property (rev_r ##1 !rev_r);
	c_hs_out: cover property (out_hs_v_r);
endmodule : dpr_mode_ctrl

/* File: dpr_src_model.sv */
// far-side model: hs source on the input lanes and peripheral on output lane zero
`timescale 1ns/1ns
module dpr_src_model (
	input wire logic core_clk,
	output logic [3:0][1:0] input_data_lanes_lp,
	output logic [3:0] input_data_lanes_hs,
	output logic [1:0] input_clock_lane_lp,
	output logic input_clock_lane_hs,
	output logic [1:0] output_lane_zero_rx
);
	initial begin
		input_data_lanes_lp = 8'hff;
		input_data_lanes_hs = 4'h0;
		input_clock_lane_lp = 2'h3;
		input_clock_lane_hs = 1'b0;
		output_lane_zero_rx = 2'h3;
	end
	// all lanes move together; held 5 cycles, above the receiver's 3
	task automatic lp_step(input logic [1:0] s);
		@(negedge core_clk);
		input_data_lanes_lp = {4{s}};
		input_clock_lane_lp = s;
		repeat (4) @(negedge core_clk);
	endtask : lp_step
	task automatic lp_seq(input logic [9:0] seq, input int n);
		for (int i = n - 1; i >= 0; i--) lp_step(seq[2*i +: 2]);
	endtask : lp_seq
	// one ddr edge every 200 ns; clock rests between frames
	task automatic hs_edge(input logic [3:0] w);
		@(negedge core_clk);
		input_data_lanes_hs = w;
		repeat (2) @(negedge core_clk);
		input_clock_lane_hs = ~input_clock_lane_hs;
		@(negedge core_clk);
		input_data_lanes_hs = ~w;
	endtask : hs_edge
	// the peripheral answers only on lane zero
	task automatic rev_seq(input logic [9:0] seq, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge core_clk);
			output_lane_zero_rx = seq[2*i +: 2];
			repeat (4) @(negedge core_clk);
		end
	endtask : rev_seq
endmodule : dpr_src_model

/* File: test_dpr_mode_ctrl.sv */
// self-checking bench of the re-timer mode control
`timescale 1ns/1ns
module test_dpr_mode_ctrl;
	import dpr_pkg::*;
	logic core_clk = 1'b0;
	logic resetn;
	logic [3:0][1:0] input_data_lanes_lp, output_data_lanes_lp;
	logic [3:0] input_data_lanes_hs, output_data_lanes_hs;
	logic [1:0] input_clock_lane_lp, output_clock_lane_lp, input_lane_zero_drv;
	logic [1:0] output_lane_zero_rx, eq_strap_serial_clock, edge_rate_strap_serial_data;
	logic [1:0] swing_strap, preemph_strap;
	logic input_clock_lane_hs, output_data_lanes_hs_valid, output_clock_lane_hs;
	logic hs_sink_ready, hs_overrun, input_lane_zero_oe_n, output_lane_zero_oe_n;
	logic reverse_active, hs_rx_term_en, hs_tx_term_en, deskew_en, hs_logic_en;
	dpr_ovr_t ovr;
	dpr_cfg_t cfg;
	dpr_mode_t mode;
	int fail_count = 0;
	int checks = 0;
	logic [3:0] got[$];
	// {swing, preemph, lp edge, swing_220, preemph out}
	logic [7:0] rows [9] = '{8'h00, 8'h48, 8'h82, 8'h18, 8'h54, 8'h96, 8'h2b, 8'h65, 8'ha7};

	dpr_mode_ctrl #(.NLANES(4)) dut (.core_clk, .resetn, .input_data_lanes_lp,
		.input_data_lanes_hs, .input_clock_lane_lp, .input_clock_lane_hs,
		.output_data_lanes_lp, .output_data_lanes_hs, .output_data_lanes_hs_valid,
		.output_clock_lane_lp, .output_clock_lane_hs, .hs_sink_ready, .hs_overrun,
		.input_lane_zero_drv, .input_lane_zero_oe_n, .output_lane_zero_rx,
		.output_lane_zero_oe_n, .eq_strap_serial_clock, .edge_rate_strap_serial_data,
		.swing_strap, .preemph_strap, .ovr, .cfg, .mode, .reverse_active,
		.hs_rx_term_en, .hs_tx_term_en, .deskew_en, .hs_logic_en);
	dpr_src_model src (.core_clk, .input_data_lanes_lp, .input_data_lanes_hs,
		.input_clock_lane_lp, .input_clock_lane_hs, .output_lane_zero_rx);

	always #25 core_clk = ~core_clk;
	// sampled mid-cycle, away from the edge that launches the word
	always @(negedge core_clk) begin
		if (output_data_lanes_hs_valid === 1'b1)
			got.push_back(output_data_lanes_hs);
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic do_reset(input int n);
		@(negedge core_clk);
		resetn = 1'b0;
		repeat (n) @(negedge core_clk);
		resetn = 1'b1;
	endtask : do_reset
	task automatic wr(input dpr_ovr_t v);
		@(negedge core_clk);
		ovr = v;
		@(negedge core_clk);
		ovr = '0;
	endtask : wr

	initial begin
		#500_000;
		fail_count++;
		conclude();
	end

	initial begin
		resetn = 1'b0;
		ovr = '0;
		hs_sink_ready = 1'b1;
		{eq_strap_serial_clock, edge_rate_strap_serial_data} = 4'h0;
		{swing_strap, preemph_strap} = 4'h0;
		repeat (6) @(negedge core_clk);
		// lanes sit at stop all through reset, outputs must not follow
		chk(16'(mode), 16'(DPR_SHUT));
		chk(16'(output_data_lanes_lp), 16'h0000);
		chk(16'(output_clock_lane_lp), 16'h0000);
		chk(16'(input_lane_zero_oe_n), 16'h0001);
		$display("test shutdown done");
		foreach (rows[i]) begin
			swing_strap = rows[i][7:6];
			preemph_strap = rows[i][5:4];
			eq_strap_serial_clock = 2'(i % 3);
			edge_rate_strap_serial_data = 2'((i + 1) % 3);
			do_reset(4);
			@(negedge core_clk);
			chk(16'(mode), 16'(DPR_LP));
			repeat (3) @(negedge core_clk);
			chk(16'(cfg), {8'h00, 2'(i % 3), 2'((i + 1) % 3), rows[i][3:0]});
		end
		$display("test straps done");
		// back-to-back overrides on every field
		@(negedge core_clk);
		ovr = '{rx_equalizer_setting_we: 1'b1, rx_equalizer_setting: 2'h1, default: '0};
		@(negedge core_clk);
		ovr = '{hs_edge_rate_setting_we: 1'b1, hs_edge_rate_setting: 2'h1, lp_edge_rate_setting_we: 1'b1, pre_we: 1'b1, default: '0};
		@(negedge core_clk);
		ovr = '0;
		repeat (2) @(negedge core_clk);
		chk(16'(cfg), 16'h0052);
		// a write while in reset is refused and the straps come back
		@(negedge core_clk);
		resetn = 1'b0;
		ovr = '{rx_equalizer_setting_we: 1'b1, rx_equalizer_setting: 2'h1, default: '0};
		@(negedge core_clk);
		ovr = '0;
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		repeat (4) @(negedge core_clk);
		chk(16'(cfg), 16'h0087);
		$display("test overrides done");
		@(negedge core_clk);
		src.input_data_lanes_lp = 8'h1b;
		repeat (5) @(negedge core_clk);
		chk(16'(output_data_lanes_lp), 16'h001b);
		chk(16'({hs_rx_term_en, hs_tx_term_en, deskew_en}), 16'h0000);
		$display("test lp pass done");
		src.lp_seq(10'h034, 3);
		chk(16'(mode), 16'(DPR_HS));
		chk(16'({hs_rx_term_en, hs_tx_term_en, deskew_en, hs_logic_en}), 16'h000f);
		got.delete();
		for (int i = 1; i <= 8; i++) src.hs_edge(4'(i));
		repeat (4) @(negedge core_clk);
		// four ui in the pipe: only the first four of eight words come out
		chk(16'(got.size()), 16'h0004);
		foreach (got[i]) chk(16'(got[i]), 16'(i + 1));
		$display("test hs stream done");
		// stall the sink until the two-entry buffer refuses
		hs_sink_ready = 1'b0;
		for (int i = 9; i <= 16; i++) src.hs_edge(4'(i));
		chk(16'(hs_overrun), 16'h0001);
		hs_sink_ready = 1'b1;
		repeat (4) @(negedge core_clk);
		src.lp_step(2'h3);
		chk(16'(mode), 16'(DPR_LP));
		chk(16'({hs_rx_term_en, hs_tx_term_en, deskew_en}), 16'h0000);
		chk(16'(output_data_lanes_hs), 16'h0000);
		got.delete();
		// link edges in lp must neither pop nor clock the hs output
		src.hs_edge(4'h5);
		repeat (4) @(negedge core_clk);
		chk(16'(got.size()), 16'h0000);
		chk(16'(output_clock_lane_hs), 16'h0000);
		$display("test hs exit done");
		src.lp_seq(10'h384, 5);
		chk(16'(mode), 16'(DPR_ULPS));
		chk(16'(hs_logic_en), 16'h0000);
		wr('{pre_we: 1'b1, pre: 1'b0, default: '0});
		repeat (2) @(negedge core_clk);
		chk(16'(cfg.preemph), 16'h0000);
		src.lp_step(2'h3);
		chk(16'(mode), 16'(DPR_LP));
		$display("test ulps done");
		src.lp_seq(10'h388, 5);
		chk(16'({reverse_active, input_lane_zero_oe_n, output_lane_zero_oe_n}), 16'h0005);
		src.rev_seq(10'h001, 1);
		chk(16'(input_lane_zero_drv), 16'h0001);
		src.rev_seq(10'h388, 5);
		chk(16'({reverse_active, input_lane_zero_oe_n}), 16'h0001);
		$display("test reverse done");
		conclude();
	end
endmodule : test_dpr_mode_ctrl
